// ---- hw/plr_defs.vh ----
// constants shared by the power-loss restore and fan control block
// assumes a 25 MHz controller clock and a plain register port
`ifndef PLR_DEFS_VH
`define PLR_DEFS_VH

// ==========================================
// clock and timing
`define PLR_CLK_HZ 25000000
`define PLR_WIN_SEC 30
`define PLR_GATE_SEC 1
`define PLR_PWM_DIV 4
`define PLR_TACH_PPR 2
`define PLR_SEC_PER_MIN 60

// ==========================================
// register offsets (byte addresses)
`define PLR_REG_CTRL 8'h00
`define PLR_REG_STAT 8'h04
`define PLR_REG_DUTY 8'h08
`define PLR_REG_RPM 8'h0C
`define PLR_REG_RUNT 8'h10
`define PLR_REG_BOOT 8'h14
`define PLR_REG_WDCT 8'h18
`define PLR_REG_WDT0 8'h1C
`define PLR_REG_WDT1 8'h20
`define PLR_REG_KICK 8'h24
`define PLR_REG_WDST 8'h28

// ==========================================
// control fields and reset values
`define PLR_POL_LSB 0
`define PLR_POL_MSB 1
`define PLR_GPIO_BIT 2
`define PLR_POL_ON 2'h0
`define PLR_POL_OFF 2'h1
`define PLR_POL_LAST 2'h2
`define PLR_CTRL_RST 3'h2
`define PLR_DUTY_RST 8'hFF

// ==========================================
// watchdog control fields and actions
`define PLR_WD_EN_BIT 0
`define PLR_WD_A0_LSB 1
`define PLR_WD_A1_LSB 3
`define PLR_ACT_NONE 2'h0
`define PLR_ACT_RST 2'h1
`define PLR_ACT_OFF 2'h2
`define PLR_WDT_RST 32'h0000_FFFF

`endif

// ---- hw/plr_fan.v ----
// pwm fan drive and tachometer speed measurement
// assumes tach input synchronous to clock_i and a one-cycle gate tick
`include "plr_defs.vh"

module plr_fan (
   input wire clock_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire gpio_mode_i,
   input wire [7:0] duty_i,
   input wire gate_tick_i,
   input wire fan_tach_pin_i,
   output reg fan_pwm_pin_o,
   output reg [15:0] rpm_o
);

   // ==========================================
   // pwm: duty sets on-time, supply stays fixed
   reg [1:0] div_q; // prescaler, about 24 kHz pwm
   reg [7:0] cnt_q; // pwm ramp
   reg tach_q; // previous tach level
   reg [10:0] pulse_q; // rising edges in current gate

   // rpm = pulses per gate * 60 / pulses per rev
   localparam [31:0] RPM_MUL =
      `PLR_SEC_PER_MIN / (`PLR_TACH_PPR * `PLR_GATE_SEC);
   localparam [31:0] DIV_LAST = `PLR_PWM_DIV - 1; // last prescaler step
   wire [31:0] prod; // full-width product, top bits always zero
   wire [15:0] scaled;
   assign prod = pulse_q * RPM_MUL;
   assign scaled = prod[15:0];

   // pwm ramp and output
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= 2'h0;
         cnt_q <= 8'h00;
         fan_pwm_pin_o <= 1'b0;
      end else if (ce_i) begin
         div_q <= div_q + 2'h1;
         if (div_q == DIV_LAST[1:0]) begin
            cnt_q <= cnt_q + 8'h01;
         end
         // pins given to gpio: fan drive off
         fan_pwm_pin_o <= ~gpio_mode_i & (cnt_q < duty_i);
      end
   end

   // tach edge count over a fixed gate
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tach_q <= 1'b0;
         pulse_q <= 11'h000;
         rpm_o <= 16'h0000;
      end else if (ce_i) begin
         tach_q <= fan_tach_pin_i;
         if (gpio_mode_i) begin
            pulse_q <= 11'h000;
            rpm_o <= 16'h0000;
         end else if (gate_tick_i) begin
            rpm_o <= scaled;
            pulse_q <= {10'h000, fan_tach_pin_i & ~tach_q};
         end else if (fan_tach_pin_i & ~tach_q & ~&pulse_q) begin
            pulse_q <= pulse_q + 11'h001;
         end
      end
   end

endmodule // plr_fan

// ---- hw/plr_wdog.v ----
// two-stage watchdog retriggered only by software kicks
// assumes kick is a one-cycle strobe from the register port
`include "plr_defs.vh"

module plr_wdog (
   input wire clock_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire enable_i,
   input wire [3:0] acts_i,
   input wire [31:0] time0_i,
   input wire [31:0] time1_i,
   input wire kick_i,
   output reg [3:0] state_o,
   output reg reset_req_o,
   output reg off_req_o
);

   // ==========================================
   // one-hot stage states
   localparam [3:0] WD_IDLE = 4'b0001;
   localparam [3:0] WD_ST0 = 4'b0010;
   localparam [3:0] WD_ST1 = 4'b0100;
   localparam [3:0] WD_DONE = 4'b1000;

   reg [31:0] cnt_q; // cycles spent in current stage
   reg [1:0] act; // action of the stage that expires
   reg [31:0] lim; // timeout of the current stage

   // pick action and limit for the running stage
   always @* begin
      act = acts_i[1:0];
      lim = time0_i;
      if (state_o == WD_ST1) begin
         act = acts_i[3:2];
         lim = time1_i;
      end
   end

   // stage sequencer; no hardware trigger input exists
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_o <= WD_IDLE;
         cnt_q <= 32'h0000_0000;
         reset_req_o <= 1'b0;
         off_req_o <= 1'b0;
      end else if (ce_i) begin
         reset_req_o <= 1'b0;
         off_req_o <= 1'b0;
         cnt_q <= cnt_q + 32'h0000_0001;
         if (!enable_i) begin
            state_o <= WD_IDLE;
         end else if (kick_i) begin
            state_o <= WD_ST0;
            cnt_q <= 32'h0000_0000;
         end else begin
            case (state_o)
               WD_IDLE: begin
                  state_o <= WD_ST0;
                  cnt_q <= 32'h0000_0000;
               end
               WD_ST0, WD_ST1: begin
                  if (cnt_q >= lim) begin
                     // code 3 would be nmi: unsupported, acts as none
                     reset_req_o <= (act == `PLR_ACT_RST);
                     off_req_o <= (act == `PLR_ACT_OFF);
                     state_o <= (state_o == WD_ST0) ? WD_ST1 : WD_DONE;
                     cnt_q <= 32'h0000_0000;
                  end
               end
               WD_DONE: state_o <= WD_DONE;
               default: state_o <= WD_IDLE;
            endcase
         end
      end
   end

endmodule // plr_wdog

// ---- hw/plr_top.v ----
// board management controller logic: power-loss restore, fan, watchdog,
// runtime meter and boot counter behind a plain register port.
// assumes standby_ok_i and system_on_i synchronous to clock_i, and that
// this logic stays powered (backup) while the standby rail is watched.
//
// Function
// - watch standby rail continuously after off or loss
// - rail valid whole window means proper off
// - rail lost within window means ac loss
// - on standby return apply on, off, last policy
// - window runs only under last-state policy
// - last state may stay on near shutdown
// - fan speed set by pwm duty only
// - rpm from tach assuming two pulses per rev
// - gpio pin mode disables pwm and tach
// - multistage watchdog, software kick only
// - no nmi stage action offered
// - keep runtime meter and boot counter
`include "plr_defs.vh"

module plr_top #(
   // 30 s window in cycles, shorten for simulation
   parameter WIN_CYCLES = `PLR_WIN_SEC * `PLR_CLK_HZ,
   // one second of clock cycles, shorten for simulation
   parameter SEC_CYCLES = `PLR_GATE_SEC * `PLR_CLK_HZ
) (
   input wire clock_i,
   input wire reset_n_i,
   input wire ce_i,
   input wire [7:0] addr_i,
   input wire [31:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rd_data_o,
   input wire standby_ok_i,
   input wire system_on_i,
   output reg power_on_req_o,
   output wire fan_pwm_pin_o,
   input wire fan_tach_pin_i,
   output wire wdog_reset_o,
   output wire wdog_off_o
);

   // ==========================================
   // reset release through two flops
   reg rst_s1_q; // first stage, read only by the second
   reg rst_n_q; // released reset used everywhere

   // async assert, sync release
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // ==========================================
   // software visible state
   reg [2:0] ctrl_q; // policy and gpio mode
   reg [7:0] duty_q; // fan pwm duty
   reg [4:0] wdct_q; // watchdog enable and stage actions
   reg [31:0] wdt0_q; // stage 0 timeout, cycles
   reg [31:0] wdt1_q; // stage 1 timeout, cycles
   reg kick_q; // one-cycle retrigger strobe
   reg [31:0] runt_q; // seconds spent powered on
   reg [31:0] boot_q; // number of power-ups seen

   wire [1:0] policy; // selected restore policy
   wire gpio_mode; // shared pins given to gpio 5 and 6
   assign policy = ctrl_q[`PLR_POL_MSB:`PLR_POL_LSB];
   assign gpio_mode = ctrl_q[`PLR_GPIO_BIT];

   // ==========================================
   // power-loss state machine, one-hot
   localparam [2:0] PL_SETTLED = 3'b001; // on, or off and classified
   localparam [2:0] PL_WINDOW = 3'b010; // timing the 30 s window
   localparam [2:0] PL_LOST = 3'b100; // ac loss, waiting for standby

   reg [2:0] pl_q; // power-loss state
   reg [29:0] win_q; // window cycle counter
   reg sby_q; // standby level one cycle back
   reg son_q; // system-on level one cycle back
   reg last_on_q; // recorded on/off state before loss
   reg proper_off_q; // last event classified as proper off

   wire sby_fall; // standby rail went away
   wire sby_rise; // standby rail came back
   wire son_fall; // orderly switch-off to soft-off
   wire son_rise; // system has booted
   wire win_end; // window fully elapsed
   assign sby_fall = sby_q & ~standby_ok_i;
   assign sby_rise = ~sby_q & standby_ok_i;
   assign son_fall = son_q & ~system_on_i;
   assign son_rise = ~son_q & system_on_i;
   localparam [31:0] WIN_LAST = WIN_CYCLES - 1; // last window cycle
   assign win_end = (win_q == WIN_LAST[29:0]);

   // edge history of the watched levels, sampled every cycle
   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sby_q <= 1'b0;
         son_q <= 1'b0;
      end else if (ce_i) begin
         sby_q <= standby_ok_i;
         son_q <= system_on_i;
      end
   end

   // classification of off and loss events and restore on return
   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pl_q <= PL_SETTLED;
         win_q <= 30'h0000_0000;
         last_on_q <= 1'b0;
         proper_off_q <= 1'b0;
         power_on_req_o <= 1'b0;
      end else if (ce_i) begin
         power_on_req_o <= 1'b0;
         case (pl_q)
            PL_SETTLED: begin
               if (system_on_i) begin
                  last_on_q <= 1'b1;
               end
               if (sby_fall) begin
                  // loss with system on keeps last state on
                  pl_q <= PL_LOST;
               end else if (son_fall && policy == `PLR_POL_LAST) begin
                  // only last-state mode needs the window
                  pl_q <= PL_WINDOW;
                  win_q <= 30'h0000_0000;
                  proper_off_q <= 1'b0;
               end else if (son_fall) begin
                  // other policies: off is off at once
                  last_on_q <= 1'b0;
               end
            end
            PL_WINDOW: begin
               // last state still reads on here; a loss now restores on
               win_q <= win_q + 30'h0000_0001;
               if (!standby_ok_i) begin
                  pl_q <= PL_LOST;
               end else if (son_rise) begin
                  pl_q <= PL_SETTLED;
               end else if (win_end) begin
                  pl_q <= PL_SETTLED;
                  last_on_q <= 1'b0;
                  proper_off_q <= 1'b1;
               end
            end
            PL_LOST: begin
               if (sby_rise) begin
                  pl_q <= PL_SETTLED;
                  case (policy)
                     `PLR_POL_ON: power_on_req_o <= 1'b1;
                     `PLR_POL_OFF: power_on_req_o <= 1'b0;
                     `PLR_POL_LAST: power_on_req_o <= last_on_q;
                     default: power_on_req_o <= 1'b0;
                  endcase
                  proper_off_q <= 1'b0;
               end
            end
            default: pl_q <= PL_SETTLED;
         endcase
      end
   end

   // ==========================================
   // runtime meter and boot counter
   reg [24:0] sec_q; // one-second prescaler
   reg gate_q; // one-cycle tick each second
   localparam [31:0] SEC_LAST = SEC_CYCLES - 1; // last prescaler count

   // seconds tick also gates the tachometer count
   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sec_q <= 25'h000_0000;
         gate_q <= 1'b0;
      end else if (ce_i) begin
         gate_q <= 1'b0;
         sec_q <= sec_q + 25'h000_0001;
         if (sec_q == SEC_LAST[24:0]) begin
            sec_q <= 25'h000_0000;
            gate_q <= 1'b1;
         end
      end
   end

   // counters held across power states; only a hard reset clears them
   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         runt_q <= 32'h0000_0000;
         boot_q <= 32'h0000_0000;
      end else if (ce_i) begin
         if (gate_q && system_on_i) begin
            runt_q <= runt_q + 32'h0000_0001;
         end
         if (son_rise) begin
            boot_q <= boot_q + 32'h0000_0001;
         end
      end
   end

   // ==========================================
   // fan drive and speed measurement
   wire [15:0] rpm; // latest measured speed

   plr_fan u_fan (
      .clock_i(clock_i),
      .rst_n_i(rst_n_q),
      .ce_i(ce_i),
      .gpio_mode_i(gpio_mode),
      .duty_i(duty_q),
      .gate_tick_i(gate_q),
      .fan_tach_pin_i(fan_tach_pin_i),
      .fan_pwm_pin_o(fan_pwm_pin_o),
      .rpm_o(rpm)
   );

   // ==========================================
   // watchdog
   wire [3:0] wd_state; // one-hot stage

   plr_wdog u_wdog (
      .clock_i(clock_i),
      .rst_n_i(rst_n_q),
      .ce_i(ce_i),
      .enable_i(wdct_q[`PLR_WD_EN_BIT]),
      .acts_i(wdct_q[4:1]),
      .time0_i(wdt0_q),
      .time1_i(wdt1_q),
      .kick_i(kick_q),
      .state_o(wd_state),
      .reset_req_o(wdog_reset_o),
      .off_req_o(wdog_off_o)
   );

   // ==========================================
   // register writes
   // kick is registered, so the watchdog restarts one cycle later
   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl_q <= `PLR_CTRL_RST;
         duty_q <= `PLR_DUTY_RST;
         wdct_q <= 5'h00;
         wdt0_q <= `PLR_WDT_RST;
         wdt1_q <= `PLR_WDT_RST;
         kick_q <= 1'b0;
      end else if (ce_i) begin
         kick_q <= 1'b0;
         if (wr_i) begin
            case (addr_i)
               `PLR_REG_CTRL: ctrl_q <= wr_data_i[2:0];
               `PLR_REG_DUTY: duty_q <= wr_data_i[7:0];
               `PLR_REG_WDCT: wdct_q <= wr_data_i[4:0];
               `PLR_REG_WDT0: wdt0_q <= wr_data_i;
               `PLR_REG_WDT1: wdt1_q <= wr_data_i;
               `PLR_REG_KICK: kick_q <= 1'b1;
               default: kick_q <= 1'b0; // unmapped: ignored
            endcase
         end
      end
   end

   // ==========================================
   // register reads, data in the cycle after the strobe
   reg [31:0] rd_mux; // selected read word

   // unmapped and write-only offsets read as zero
   always @* begin
      case (addr_i)
         `PLR_REG_CTRL: rd_mux = {29'h0000_0000, ctrl_q};
         `PLR_REG_STAT: rd_mux = {26'h000_0000, proper_off_q,
            pl_q[1], pl_q[2], last_on_q, system_on_i, standby_ok_i};
         `PLR_REG_DUTY: rd_mux = {24'h00_0000, duty_q};
         `PLR_REG_RPM: rd_mux = {16'h0000, rpm};
         `PLR_REG_RUNT: rd_mux = runt_q;
         `PLR_REG_BOOT: rd_mux = boot_q;
         `PLR_REG_WDCT: rd_mux = {27'h000_0000, wdct_q};
         `PLR_REG_WDT0: rd_mux = wdt0_q;
         `PLR_REG_WDT1: rd_mux = wdt1_q;
         `PLR_REG_WDST: rd_mux = {28'h000_0000, wd_state};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data stands for one cycle only, zero otherwise
   always @(posedge clock_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_data_o <= 32'h0000_0000;
      end else if (ce_i) begin
         rd_data_o <= rd_i ? rd_mux : 32'h0000_0000;
      end
   end

endmodule // plr_top

// ---- tb/plr_top_asserts.sv ----
// port checker for the power-loss restore, fan and watchdog block
// assumes it is bound onto plr_top; reset_n_i is async, active low
module plr_top_asserts #(
   parameter WIN_CYCLES = 100,
   parameter SEC_CYCLES = 50
) (
   input wire clock_i,
   input wire reset_n_i,
   input wire ce_i,
   input wire [7:0] addr_i,
   input wire [31:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rd_data_o,
   input wire standby_ok_i,
   input wire system_on_i,
   input wire power_on_req_o,
   input wire fan_pwm_pin_o,
   input wire fan_tach_pin_i,
   input wire wdog_reset_o,
   input wire wdog_off_o
);
   // ==========================================
   // sequences
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);
   // software switches the shared pins to gpio use
   sequence s_gpio_wr;
      ce_i && wr_i && addr_i == 8'h00 && wr_data_i[2];
   endsequence
   // pwm held low for a whole ramp step
   sequence s_pwm_low;
      !fan_pwm_pin_o [*4];
   endsequence
   // ==========================================
   // properties
   property p_req_one;
      power_on_req_o |=> !power_on_req_o [*3];
   endproperty
   // a request only follows a fresh return of the rail
   property p_req_cause;
      power_on_req_o |-> standby_ok_i && $past(standby_ok_i) &&
         (!$past(standby_ok_i, 2) || !$past(standby_ok_i, 3));
   endproperty
   // status bit 0 shows the live rail level
   property p_stat_live;
      ce_i && rd_i && addr_i == 8'h04 |=>
         rd_data_o[0] == $past(standby_ok_i);
   endproperty
   property p_rd_stands;
      !$past(rd_i && ce_i) |-> rd_data_o == 32'h0000_0000;
   endproperty
   // kick word is write-only
   property p_kick_rd;
      ce_i && rd_i && addr_i == 8'h24 |=> rd_data_o == 32'h0000_0000;
   endproperty
   property p_wd_rst_one;
      wdog_reset_o |=> !wdog_reset_o;
   endproperty
   property p_wd_off_one;
      wdog_off_o |=> !wdog_off_o;
   endproperty
   // one stage acts at a time
   property p_wd_excl;
      !(wdog_reset_o && wdog_off_o);
   endproperty
   property p_gpio_pwm;
      s_gpio_wr |-> ##2 s_pwm_low;
   endproperty
   a_req_one: assert property (p_req_one)
      else $error("restore request longer than one cycle");
   a_req_cause: assert property (p_req_cause)
      else $error("restore request without rail return");
   a_stat_live: assert property (p_stat_live)
      else $error("status rail bit wrong");
   a_rd_stands: assert property (p_rd_stands)
      else $error("read data not zero outside read slot");
   a_kick_rd: assert property (p_kick_rd)
      else $error("kick word read not zero");
   a_wd_rst_one: assert property (p_wd_rst_one)
      else $error("reset action longer than one cycle");
   a_wd_off_one: assert property (p_wd_off_one)
      else $error("off action longer than one cycle");
   a_wd_excl: assert property (p_wd_excl)
      else $error("both stage actions at once");
   a_gpio_pwm: assert property (p_gpio_pwm)
      else $error("pwm still driven in gpio mode");
endmodule // plr_top_asserts

bind plr_top plr_top_asserts #(
   .WIN_CYCLES(WIN_CYCLES),
   .SEC_CYCLES(SEC_CYCLES)
) u_plr_top_asserts (
   .clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
   .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
   .rd_data_o(rd_data_o), .standby_ok_i(standby_ok_i),
   .system_on_i(system_on_i), .power_on_req_o(power_on_req_o),
   .fan_pwm_pin_o(fan_pwm_pin_o), .fan_tach_pin_i(fan_tach_pin_i),
   .wdog_reset_o(wdog_reset_o), .wdog_off_o(wdog_off_o)
);

// ---- tb/plr_partner.sv ----
// carrier side: switched standby rail and a four-wire fan
// assumes bench commands that change just after clock_i edges
module plr_partner (
   input wire clock_i,
   input wire rail_up_i,
   input wire fan_run_i,
   input wire fan_pwm_pin_i,
   output logic standby_ok_o,
   output logic fan_tach_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] rev_q = 5'h00; // position within one revolution
   // ==========================================
   // rail follows the command one cycle late, like a slow supply
   always @(posedge clock_i) begin
      standby_ok_o <= rail_up_i;
   end
   // fan supply is constant, only the pwm level would set speed
   // speed here is fixed so the expected count stays exact
   always @(posedge clock_i) begin
      if (!fan_run_i) begin
         rev_q <= 5'h00;
         fan_tach_pin_o <= 1'b1; // pulled up while stopped
      end else begin
         rev_q <= (rev_q == 5'h13) ? 5'h00 : rev_q + 5'h01;
         fan_tach_pin_o <= (rev_q % 10) < 5;
      end
   end
endmodule // plr_partner

// ---- tb/tb.sv ----
// self-checking bench for the power-loss restore block
// assumes plr_top built with a short window and a short gate
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WIN = 100; // shortened restore window
   localparam int SEC = 50; // shortened one-second gate
   logic clk, rst_n, wr, rd, rail, fan, sys, rd_v, ce;
   logic [7:0] addr, d;
   logic [31:0] wdat;
   wire [31:0] rdat;
   wire stby, req, pwm, tach, wrst, woff;
   logic [31:0] qe[$], qm[$]; // expected read value and mask
   int fail_count, n_tests, boots, pwr, nrst, noff, hi, k, i;
   logic [7:0] ra[8] = '{8'h00, 8'h08, 8'h18, 8'h1C, 8'h20, 8'h24,
      8'h28, 8'h3C};
   logic [31:0] rv[8] = '{32'h0000_0002, 32'h0000_00FF, 0,
      32'h0000_FFFF, 32'h0000_FFFF, 0, 32'h0000_0001, 0};
   logic [7:0] dv[4] = '{8'h00, 8'h00, 8'h80, 8'hFF};
   plr_top #(.WIN_CYCLES(WIN), .SEC_CYCLES(SEC)) u_plr_top (
      .clock_i(clk), .reset_n_i(rst_n), .ce_i(ce), .addr_i(addr),
      .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
      .standby_ok_i(stby), .system_on_i(sys), .power_on_req_o(req),
      .fan_pwm_pin_o(pwm), .fan_tach_pin_i(tach),
      .wdog_reset_o(wrst), .wdog_off_o(woff));
   plr_partner u_plr_partner (.clock_i(clk), .rail_up_i(rail),
      .fan_run_i(fan), .fan_pwm_pin_i(pwm), .standby_ok_o(stby),
      .fan_tach_pin_o(tach));
   // ==========================================
   // clock, compare and bus tasks
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // counts are read one step after the edge to avoid races
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1;
      addr <= a;
      wdat <= v;
      @(posedge clk);
      wr <= 0;
   endtask
   task rd_reg(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      qe.push_back(e);
      qm.push_back(m);
      @(posedge clk);
      rd <= 1;
      addr <= a;
      @(posedge clk);
      rd <= 0;
   endtask
   task son();
      @(posedge clk);
      sys <= 1;
      boots++;
   endtask
   task final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // monitor: read data against oldest note, count cycles each output is high
   always @(posedge clk) begin
      if (rd_v) begin
         chk(rdat & qm.pop_front(), qe.pop_front());
      end
      rd_v <= rd;
      pwr += (req === 1'b1);
      nrst += (wrst === 1'b1);
      noff += (woff === 1'b1);
      hi += (pwm === 1'b1);
   end
   // hang guard, well past the expected run length
   initial begin
      #1600000;
      fail_count++;
      final_report();
   end
   // ==========================================
   // main sequence
   initial begin
      {rst_n, wr, rd, addr, wdat, sys, rd_v} = 0;
      {rail, fan} = 2'b11;
      ce = 1;
      void'($urandom(32736));
      repeat (4) @(posedge clk);
      rst_n <= 1;
      cyc(3);
      // read-only and unmapped writes must leave things alone
      wr_reg(8'h3C, '1);
      wr_reg(8'h04, '1);
      for (i = 0; i < 8; i++) rd_reg(ra[i], rv[i], '1);
      rd_reg(8'h04, 32'h0000_0001, 32'h0000_0003);
      $display("reset values done");
      // ac loss under each policy, then standby returns
      for (i = 0; i < 3; i++) begin
         wr_reg(8'h00, i);
         son();
         cyc(5);
         sys <= 0;
         rail <= 0;
         cyc(5);
         rd_reg(8'h04, 32'h0000_0008, 32'h0000_0008);
         k = pwr;
         rail <= 1;
         cyc(10);
         chk(pwr - k, i != 1);
      end
      // window restarts on a second off event, then proper off
      wr_reg(8'h00, 32'h0000_0002);
      son();
      cyc(5);
      sys <= 0;
      cyc(50);
      son();
      cyc(3);
      sys <= 0;
      cyc(70);
      rd_reg(8'h04, 32'h0000_0010, 32'h0000_0030);
      cyc(40);
      rd_reg(8'h04, 32'h0000_0020, 32'h0000_0034);
      k = pwr;
      rail <= 0;
      cyc(5);
      rail <= 1;
      cyc(10);
      chk(pwr - k, 0);
      // always-on policy keeps no window and no last state
      wr_reg(8'h00, 0);
      son();
      cyc(5);
      sys <= 0;
      cyc(5);
      rd_reg(8'h04, 0, 32'h0000_0014);
      // loss soon after shutdown: either restore outcome is fine
      wr_reg(8'h00, 32'h0000_0002);
      son();
      cyc(5);
      sys <= 0;
      cyc(20);
      rail <= 0;
      cyc(5);
      rd_reg(8'h04, 32'h0000_0008, 32'h0000_0008);
      rail <= 1;
      cyc(10);
      rd_reg(8'h14, boots, '1);
      $display("power loss done");
      // duty over one whole ramp: zero, random, middle, full
      for (i = 0; i < 4; i++) begin
         d = (i == 1) ? $urandom_range(254, 1) : dv[i];
         wr_reg(8'h08, d);
         cyc(1100);
         k = hi;
         cyc(1024);
         chk(hi - k, d * 4);
      end
      rd_reg(8'h0C, 32'h0000_0096, '1);
      // clock enable low: a duty write must be ignored
      cyc(2);
      ce <= 0;
      wr_reg(8'h08, 0);
      ce <= 1;
      rd_reg(8'h08, 32'h0000_00FF, '1);
      // gpio use of the shared pins silences pwm and tach
      wr_reg(8'h00, 32'h0000_0006);
      cyc(10);
      k = hi;
      cyc(1024);
      chk(hi - k, 0);
      rd_reg(8'h0C, 0, '1);
      wr_reg(8'h00, 32'h0000_0002);
      fan <= 0;
      cyc(130);
      rd_reg(8'h0C, 0, '1);
      $display("fan done");
      // two stages: reset action then power-off action
      wr_reg(8'h1C, 32'h0000_0005);
      wr_reg(8'h20, 32'h0000_0005);
      wr_reg(8'h18, 32'h0000_0013);
      cyc(40);
      chk(nrst, 1);
      chk(noff, 1);
      rd_reg(8'h28, 32'h0000_0008, '1);
      // no-action code stands where an nmi mode would be; kick
      wr_reg(8'h18, 0);
      wr_reg(8'h1C, 32'h0000_00C8);
      wr_reg(8'h20, 32'h0000_00C8);
      wr_reg(8'h18, 32'h0000_001F);
      rd_reg(8'h28, 32'h0000_0002, '1);
      cyc(150);
      wr_reg(8'h24, 0);
      cyc(100);
      rd_reg(8'h28, 32'h0000_0002, '1);
      cyc(500);
      rd_reg(8'h28, 32'h0000_0008, '1);
      chk(nrst + noff, 2);
      cyc(3);
      $display("watchdog done");
      final_report();
   end
endmodule // tb
